// >>> hdl/pscm_power_clock.sv
// ------------------------------------------------------------
// Function
// - monitor enabled only by configuration strap
// - monitor on: reference osc runs, watchdog ignored
// - failure raises trap, falls back to fast rc
// - pll in use: fall back to fast rc pll
// - unlocked: next osc select write switches source
// - sleep stops cpu, peripheral and system osc clocks, idle halts cpu
// - interrupt, reset or watchdog timeout wakes
// - sleep shuts system clock source down
// - monitor inactive throughout sleep
// - sleep keeps reference osc if watchdog on
// - watchdog cleared on sleep or idle entry
// - sleep disables system clocked peripherals
// - wake from sleep on same source
// - idle keeps system clock and peripherals
// - idle keeps reference osc for watchdog/monitor
// - idle wake restores cpu clock at once
// - interrupt during entry deferred, then wakes
// - doze slows cpu only, peripherals unchanged
// - doze enable bit plus 3-bit ratio
// - restore on interrupt returns full speed
// - ratio code n divides by 2**n
// - doze enable clear forces 1:1
// - interrupt with restore clears doze enable
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module pscm_power_clock
  import pscm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cfg_fsm_enable_i,
  input  wire logic        cfg_switch_enable_i,
  input  wire logic        cfg_wdt_enable_i,
  input  wire logic [2:0]  cfg_init_osc_i,
  input  wire logic        power_save_instruction_exec_i,
  input  wire logic        power_save_instruction_idle_i,
  input  wire logic        irq_pending_i,
  input  wire logic        wdt_timeout_i,
  input  wire logic        osc_alive_i,
  input  wire logic        low_power_rc_osc_tick_i,
  output logic [2:0]       osc_select_o,
  output logic             fail_trap_o,
  output logic             low_power_rc_osc_enable_o,
  output logic             sysosc_enable_o,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             periph_sleep_off_o,
  output logic             cpu_halt_o,
  output logic             wdt_clear_o,
  output logic             wake_o
);

  // ------------------------------------------------------------
  // configuration capture
  // ------------------------------------------------------------
  logic            cfg_done_reg;
  logic            fsm_en_reg;
  logic            switch_en_reg;
  logic            wdt_en_reg;

  // straps are caught once after reset release; run-time logic cannot change them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_done_reg  <= 1'b0;
      fsm_en_reg    <= 1'b0;
      switch_en_reg <= 1'b0;
      wdt_en_reg    <= 1'b0;
    end else if (!cfg_done_reg) begin
      cfg_done_reg  <= 1'b1;
      fsm_en_reg    <= cfg_fsm_enable_i;
      switch_en_reg <= cfg_switch_enable_i;
      wdt_en_reg    <= cfg_wdt_enable_i;
    end
  end

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic            bus_req;
  logic            wr_div;
  logic            wr_osc;
  pscm_power_save_instruction_type power_save_instruction;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_div  = bus_req && wb_we_i && (wb_adr_i == ADR_CLK_DIV);
  assign wr_osc  = bus_req && wb_we_i && (wb_adr_i == ADR_OSC_CONTROL);
  assign power_save_instruction  = '{exec: power_save_instruction_exec_i, idle: power_save_instruction_idle_i};

  // ------------------------------------------------------------
  // power state machine
  // ------------------------------------------------------------
  pscm_state_type  state_reg;
  pscm_state_type  state_next;
  logic            mode_idle_reg;
  logic            wake_event;

  assign wake_event = irq_pending_i || wdt_timeout_i;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PS_RUN: begin
        if (power_save_instruction.exec) begin
          state_next = PS_ENTER;
        end
      end
      // interrupts are not looked at here, they wait for the low power state
      PS_ENTER: begin
        state_next = mode_idle_reg ? PS_IDLE : PS_SLEEP;
      end
      PS_SLEEP, PS_IDLE: begin
        if (wake_event) begin
          state_next = PS_RUN;
        end
      end
      default: begin
        state_next = PS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= PS_RUN;
      mode_idle_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == PS_RUN && power_save_instruction.exec) begin
        mode_idle_reg <= power_save_instruction.idle;
      end
    end
  end

  logic            in_sleep;
  logic            in_idle;
  assign in_sleep = (state_reg == PS_SLEEP);
  assign in_idle  = (state_reg == PS_IDLE);

  // ------------------------------------------------------------
  // oscillator selection and lock
  // ------------------------------------------------------------
  logic [2:0]      osc_cur_reg;
  logic [2:0]      osc_next_reg;
  logic            lock_reg;
  logic            fail_flag_reg;
  logic            fail_event;

  // source is held untouched through sleep, so wake resumes on it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cur_reg  <= OSC_FRC;
      osc_next_reg <= OSC_FRC;
    end else if (!cfg_done_reg) begin
      osc_cur_reg  <= cfg_init_osc_i;
      osc_next_reg <= cfg_init_osc_i;
    end else if (fail_event) begin
      osc_cur_reg  <= osc_cur_reg[OSC_PLL_BIT] ? OSC_FRC_PLL : OSC_FRC;
      osc_next_reg <= osc_cur_reg[OSC_PLL_BIT] ? OSC_FRC_PLL : OSC_FRC;
    end else if (wr_osc && wb_sel_i[1] && !lock_reg && switch_en_reg) begin
      osc_next_reg <= wb_dat_i[OSC_NEXT_LSB +: 3];
      osc_cur_reg  <= wb_dat_i[OSC_NEXT_LSB +: 3];
    end
  end

  // lock has its own process so a switch and a lock in one write both land
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_reg <= 1'b0;
    end else if (cfg_done_reg && wr_osc && wb_sel_i[0] && wb_dat_i[OSC_LOCK_BIT]) begin
      lock_reg <= 1'b1;  // lock holds until reset
    end
  end

  // failure flag is write-one-to-clear; a new failure wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_flag_reg <= 1'b0;
    end else if (fail_event) begin
      fail_flag_reg <= 1'b1;
    end else if (wr_osc && wb_sel_i[0] && wb_dat_i[OSC_FAIL_BIT]) begin
      fail_flag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // fail-safe monitor
  // ------------------------------------------------------------
  logic [2:0]      alive_sync_reg;
  logic [2:0]      tick_sync_reg;
  logic [7:0]      edge_cnt_reg;
  logic            alive_rise;
  logic            tick_rise;
  logic            mon_active;
  logic            mon_armed_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alive_sync_reg <= 3'h0;
      tick_sync_reg  <= 3'h0;
    end else begin
      alive_sync_reg <= {alive_sync_reg[1:0], osc_alive_i};
      tick_sync_reg  <= {tick_sync_reg[1:0], low_power_rc_osc_tick_i};
    end
  end

  // edge detectors look only at the second and third stages
  assign alive_rise = alive_sync_reg[1] && !alive_sync_reg[2];
  assign tick_rise  = tick_sync_reg[1] && !tick_sync_reg[2];
  // no supervision in sleep; after a fallback the fast rc is trusted
  assign mon_active = fsm_en_reg && !in_sleep && !fail_flag_reg && (osc_cur_reg != OSC_LOW_POWER_RC_OSC);
  assign fail_event = mon_active && mon_armed_reg && tick_rise && (edge_cnt_reg < FAIL_MIN_EDGES);

  // a partial first reference period after wake or restart is not judged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_armed_reg <= 1'b0;
    end else if (!mon_active) begin
      mon_armed_reg <= 1'b0;
    end else if (tick_rise) begin
      mon_armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_cnt_reg <= 8'h00;
    end else if (!mon_active || tick_rise) begin
      edge_cnt_reg <= 8'h00;
    end else if (alive_rise && edge_cnt_reg != 8'hff) begin
      edge_cnt_reg <= edge_cnt_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // doze control
  // ------------------------------------------------------------
  pscm_doze_type   doze_reg;
  logic            irq_rise;
  logic            irq_prev_reg;

  assign irq_rise = irq_pending_i && !irq_prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_prev_reg <= 1'b0;
    end else begin
      irq_prev_reg <= irq_pending_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      doze_reg <= '{restore_on_interrupt: 1'b0, ratio: RATIO_RESET, cpu_slowdown_enable: 1'b0};
    end else begin
      if (wr_div && wb_sel_i[1]) begin
        doze_reg.restore_on_interrupt <= wb_dat_i[DIV_ROI_BIT];
        doze_reg.ratio                <= wb_dat_i[DIV_RATIO_LSB +: 3];
        doze_reg.cpu_slowdown_enable  <= wb_dat_i[DIV_EN_BIT];
      end
      // hardware clear takes priority over a write in the same cycle
      if (doze_reg.restore_on_interrupt && irq_rise) begin
        doze_reg.cpu_slowdown_enable <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // cpu clock divider
  // ------------------------------------------------------------
  logic [2:0]      ratio_act_reg;
  logic [2:0]      ratio_want;
  logic [6:0]      div_cnt_reg;
  logic [6:0]      div_mask;
  logic            div_boundary;

  assign ratio_want   = doze_reg.cpu_slowdown_enable ? doze_reg.ratio : 3'h0;
  assign div_mask     = 7'((8'h01 << ratio_act_reg) - 8'h01);
  assign div_boundary = (div_cnt_reg == div_mask);

  // the peripheral clock never sees the ratio; only the cpu enable is thinned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_reg   <= DIV_CNT_ZERO;
      ratio_act_reg <= 3'h0;
    end else if (div_boundary) begin
      div_cnt_reg   <= DIV_CNT_ZERO;
      ratio_act_reg <= ratio_want;
    end else begin
      div_cnt_reg <= div_cnt_reg + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // clock and control outputs
  // ------------------------------------------------------------
  logic            halted_next;
  assign halted_next = (state_next != PS_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o       <= 1'b0;
      periph_clk_en_o    <= 1'b0;
      periph_sleep_off_o <= 1'b0;
      cpu_halt_o         <= 1'b0;
      sysosc_enable_o    <= 1'b1;
      low_power_rc_osc_enable_o      <= 1'b0;
    end else begin
      cpu_clk_en_o       <= !halted_next && div_boundary;
      periph_clk_en_o    <= (state_next != PS_SLEEP);
      periph_sleep_off_o <= (state_next == PS_SLEEP);
      cpu_halt_o         <= halted_next;
      sysosc_enable_o    <= (state_next != PS_SLEEP);
      // with the monitor on, the watchdog has no say outside sleep
      low_power_rc_osc_enable_o      <= (fsm_en_reg && (state_next != PS_SLEEP))
                            || wdt_en_reg
                            || (osc_cur_reg == OSC_LOW_POWER_RC_OSC && state_next != PS_SLEEP);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_select_o <= OSC_FRC;
      fail_trap_o  <= 1'b0;
      wdt_clear_o  <= 1'b0;
      wake_o       <= 1'b0;
    end else begin
      osc_select_o <= osc_cur_reg;
      fail_trap_o  <= fail_event;
      wdt_clear_o  <= wdt_en_reg && (state_reg == PS_RUN) && power_save_instruction.exec;
      wake_o       <= (in_sleep || in_idle) && wake_event;
    end
  end

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------
  logic [31:0]     rd_data;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      ADR_CLK_DIV: begin
        rd_data[DIV_ROI_BIT]          = doze_reg.restore_on_interrupt;
        rd_data[DIV_RATIO_LSB +: 3]   = doze_reg.ratio;
        rd_data[DIV_EN_BIT]           = doze_reg.cpu_slowdown_enable;
      end
      ADR_OSC_CONTROL: begin
        rd_data[OSC_CUR_LSB +: 3]     = osc_cur_reg;
        rd_data[OSC_NEXT_LSB +: 3]    = osc_next_reg;
        rd_data[OSC_LOCK_BIT]         = lock_reg;
        rd_data[OSC_FAIL_BIT]         = fail_flag_reg;
      end
      ADR_POWER_STATUS: begin
        rd_data[PST_MODE_LSB +: 2]    = state_reg;
        rd_data[PST_FSM_EN_BIT]       = fsm_en_reg;
        rd_data[PST_LOW_POWER_RC_OSC_BIT]         = low_power_rc_osc_enable_o;
        rd_data[PST_SYSOSC_BIT]       = sysosc_enable_o;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rd_data : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// >>> shared/pscm_pkg.sv
package pscm_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ------------------------------------------------------------
  localparam logic [3:0]  ADR_CLK_DIV       = 4'h0;
  localparam logic [3:0]  ADR_OSC_CONTROL   = 4'h4;
  localparam logic [3:0]  ADR_POWER_STATUS  = 4'h8;

  // clock divide register fields
  localparam int          DIV_ROI_BIT       = 15;
  localparam int          DIV_RATIO_LSB     = 12;
  localparam int          DIV_EN_BIT        = 11;
  localparam logic [2:0]  RATIO_RESET       = 3'h0;

  // osc control register fields
  localparam int          OSC_CUR_LSB       = 12;
  localparam int          OSC_NEXT_LSB      = 8;
  localparam int          OSC_LOCK_BIT      = 7;
  localparam int          OSC_FAIL_BIT      = 3;

  // power status register fields
  localparam int          PST_MODE_LSB      = 0;
  localparam int          PST_FSM_EN_BIT    = 4;
  localparam int          PST_LOW_POWER_RC_OSC_BIT      = 5;
  localparam int          PST_SYSOSC_BIT    = 6;

  // ------------------------------------------------------------
  // oscillator source codes (bit 0 set means through the pll, except low power rc code 5)
  // ------------------------------------------------------------
  localparam logic [2:0]  OSC_FRC           = 3'h0;
  localparam logic [2:0]  OSC_FRC_PLL       = 3'h1;
  localparam logic [2:0]  OSC_PRI           = 3'h2;
  localparam logic [2:0]  OSC_PRI_PLL       = 3'h3;
  localparam logic [2:0]  OSC_LOW_POWER_RC_OSC          = 3'h5;
  localparam int          OSC_PLL_BIT       = 0;

  // fewer system clock edges than this per reference period is a failure
  localparam logic [7:0]  FAIL_MIN_EDGES    = 8'h02;
  localparam logic [6:0]  DIV_CNT_ZERO      = 7'h00;

  typedef enum logic [1:0] {
    PS_RUN,
    PS_ENTER,
    PS_SLEEP,
    PS_IDLE
  } pscm_state_type;

  typedef struct packed {
    logic       restore_on_interrupt;
    logic [2:0] ratio;
    logic       cpu_slowdown_enable;
  } pscm_doze_type;

  typedef struct packed {
    logic       exec;
    logic       idle;
  } pscm_power_save_instruction_type;

endpackage

// >>> verification/pscm_power_clock_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module pscm_power_clock_checker (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       power_save_instruction_exec_i,
  input  wire logic       power_save_instruction_idle_i,
  input  wire logic       irq_pending_i,
  input  wire logic       wdt_timeout_i,
  input  wire logic       cfg_wdt_enable_i,
  input  wire logic       cfg_fsm_enable_i,
  input  wire logic [2:0] osc_select_o,
  input  wire logic       fail_trap_o,
  input  wire logic       low_power_rc_osc_enable_o,
  input  wire logic       sysosc_enable_o,
  input  wire logic       cpu_clk_en_o,
  input  wire logic       periph_clk_en_o,
  input  wire logic       periph_sleep_off_o,
  input  wire logic       cpu_halt_o,
  input  wire logic       wdt_clear_o,
  input  wire logic       wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // halt low means the run state, so this is an accepted power-save request
  wire logic take_w = power_save_instruction_exec_i && !cpu_halt_o;

  a_halt_take: assert property (take_w |=> cpu_halt_o && wdt_clear_o == cfg_wdt_enable_i)
    else $error("halt or watchdog clear missing after power save");
  a_sleep_off: assert property (take_w && !power_save_instruction_idle_i |=> ##1 !sysosc_enable_o && !periph_clk_en_o && periph_sleep_off_o)
    else $error("sleep did not stop the clocks");
  a_idle_keep: assert property (take_w && power_save_instruction_idle_i |=> ##1 sysosc_enable_o && periph_clk_en_o && !periph_sleep_off_o
    && (low_power_rc_osc_enable_o || !(cfg_wdt_enable_i || cfg_fsm_enable_i)))
    else $error("idle stopped a clock that must run");
  a_wake_event: assert property (cpu_halt_o && $past(cpu_halt_o) && (irq_pending_i || wdt_timeout_i)
    |=> wake_o && !cpu_halt_o)
    else $error("no wake after interrupt or timeout");
  a_src_hold: assert property (!sysosc_enable_o && $past(!sysosc_enable_o) |=> $stable(osc_select_o))
    else $error("clock source changed while asleep");
  a_no_trap_sleep: assert property (!sysosc_enable_o && $past(!sysosc_enable_o) |-> !fail_trap_o)
    else $error("monitor trapped during sleep");
  a_trap_fallback: assert property (fail_trap_o |=> osc_select_o == {2'h0, $past(osc_select_o[0])})
    else $error("no fallback to fast rc after trap");
  a_trap_pulse: assert property (fail_trap_o |=> !fail_trap_o)
    else $error("trap longer than one cycle");
  a_halt_noclk: assert property (cpu_halt_o && $past(cpu_halt_o) |-> !cpu_clk_en_o)
    else $error("cpu clock enabled while halted");
  a_wake_pulse: assert property (wake_o |=> !wake_o && !cpu_halt_o)
    else $error("wake not a single pulse into run");

  c_sleep: cover property (take_w && !power_save_instruction_idle_i);
  c_idle_wake: cover property (wdt_timeout_i && cpu_halt_o ##1 wake_o);
  c_trap: cover property (fail_trap_o);
endmodule

bind pscm_power_clock pscm_power_clock_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .power_save_instruction_exec_i(power_save_instruction_exec_i), .power_save_instruction_idle_i(power_save_instruction_idle_i),
  .irq_pending_i(irq_pending_i), .wdt_timeout_i(wdt_timeout_i), .cfg_wdt_enable_i(cfg_wdt_enable_i),
  .cfg_fsm_enable_i(cfg_fsm_enable_i), .osc_select_o(osc_select_o), .fail_trap_o(fail_trap_o),
  .low_power_rc_osc_enable_o(low_power_rc_osc_enable_o), .sysosc_enable_o(sysosc_enable_o), .cpu_clk_en_o(cpu_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .periph_sleep_off_o(periph_sleep_off_o), .cpu_halt_o(cpu_halt_o),
  .wdt_clear_o(wdt_clear_o), .wake_o(wake_o));

`default_nettype wire

// >>> verification/pscm_osc_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// oscillator sources: a stopped oscillator holds its last level
// ------------------------------------------------------------
module pscm_osc_model #(
  parameter int HALF_OSC = 133,
  parameter int HALF_REF = 1307
) (
  input  wire logic osc_run_i,
  input  wire logic osc_fail_i,
  input  wire logic ref_run_i,
  output logic      osc_alive_o,
  output logic      low_power_rc_osc_tick_o
);
  initial begin
    osc_alive_o = 1'h0;
    low_power_rc_osc_tick_o = 1'h0;
  end

  // periods unrelated to the system clock so edges drift across it
  always #HALF_OSC if (osc_run_i && !osc_fail_i) osc_alive_o = !osc_alive_o;
  always #HALF_REF if (ref_run_i) low_power_rc_osc_tick_o = !low_power_rc_osc_tick_o;
endmodule

`default_nettype wire

// >>> verification/pscm_power_clock_bench.sv
`timescale 1ns/100ps
`default_nettype none

module pscm_power_clock_bench
  import pscm_pkg::*;
;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        wb_cyc_i = 1'h0;
  logic        wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic        power_save_instruction_exec_i = 1'h0;
  logic        power_save_instruction_idle_i = 1'h0;
  logic        irq_pending_i = 1'h0;
  logic        wdt_timeout_i = 1'h0;
  logic        osc_fail = 1'h0;
  logic        osc_alive_i;
  logic        low_power_rc_osc_tick_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  osc_select_o;
  logic        fail_trap_o, low_power_rc_osc_enable_o, sysosc_enable_o, cpu_clk_en_o;
  logic        periph_clk_en_o, periph_sleep_off_o, cpu_halt_o, wdt_clear_o, wake_o;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [7:0]  lfsr_reg = 8'h21;
  int          fails = 0;
  int          n_compared = 0;

  always #50 clk_i = !clk_i;

  pscm_power_clock dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cfg_fsm_enable_i(1'h1), .cfg_switch_enable_i(1'h1), .cfg_wdt_enable_i(1'h0), .cfg_init_osc_i(OSC_PRI_PLL),
    .power_save_instruction_exec_i(power_save_instruction_exec_i), .power_save_instruction_idle_i(power_save_instruction_idle_i), .irq_pending_i(irq_pending_i),
    .wdt_timeout_i(wdt_timeout_i), .osc_alive_i(osc_alive_i), .low_power_rc_osc_tick_i(low_power_rc_osc_tick_i),
    .osc_select_o(osc_select_o), .fail_trap_o(fail_trap_o), .low_power_rc_osc_enable_o(low_power_rc_osc_enable_o),
    .sysosc_enable_o(sysosc_enable_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .periph_sleep_off_o(periph_sleep_off_o), .cpu_halt_o(cpu_halt_o), .wdt_clear_o(wdt_clear_o), .wake_o(wake_o));

  pscm_osc_model osc (.osc_run_i(sysosc_enable_o), .osc_fail_i(osc_fail), .ref_run_i(low_power_rc_osc_enable_o),
    .osc_alive_o(osc_alive_i), .low_power_rc_osc_tick_o(low_power_rc_osc_tick_i));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // entry e holds expected data above and compare mask below; mask 0 means a write
  task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] d, input logic [63:0] x);
    exp_q.push_back(x);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h3;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'h1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[31:0] !== 32'h0000_0000) chk(wb_dat_o & e[31:0], e[63:32]);
    end
  end

  // waits past two full divided periods so a new ratio has surely landed
  task automatic period(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (300) @(posedge clk_i);
    while (cpu_clk_en_o !== 1'h1) @(posedge clk_i);
    do begin
      @(posedge clk_i);
      n++;
    end while (cpu_clk_en_o !== 1'h1 && n < 8'hff);
    chk({24'h00_0000, n}, {24'h00_0000, exp});
  endtask

  task automatic wait_for(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'h1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0000_0000, s}, 32'h0000_0001);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    bus(1'h0, ADR_POWER_STATUS, 32'h0000_0000, {32'h0000_0070, 32'h0000_0073});
    bus(1'h0, 4'hc, 32'h0000_0000, {32'h0000_0000, 32'hffff_ffff});
    bus(1'h0, ADR_CLK_DIV, 32'h0000_0000, {32'h0000_0000, 32'hffff_ffff});
    for (int i = 0; i < 8; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      bus(1'h1, ADR_CLK_DIV, {16'h0000, 1'h0, i[2:0], 1'h1, 3'h0, lfsr_reg}, 64'h0);
      bus(1'h0, ADR_CLK_DIV, 32'h0000_0000, {16'h0000, 1'h0, i[2:0], 1'h1, 11'h000, 32'hffff_ffff});
      period(8'h01 << i);
    end
    bus(1'h1, ADR_CLK_DIV, 32'h0000_7000, 64'h0);
    period(8'h01);
    bus(1'h1, ADR_CLK_DIV, 32'h0000_a800, 64'h0);
    irq_pending_i <= 1'h1;
    @(posedge clk_i);
    irq_pending_i <= 1'h0;
    bus(1'h0, ADR_CLK_DIV, 32'h0000_0000, {32'h0000_a000, 32'hffff_ffff});
    period(8'h01);
    // interrupt coincident with the sleep request is held off until entry
    power_save_instruction_exec_i <= 1'h1;
    power_save_instruction_idle_i <= 1'h0;
    irq_pending_i <= 1'h1;
    @(posedge clk_i);
    power_save_instruction_exec_i <= 1'h0;
    wait_for(wake_o, 8);
    irq_pending_i <= 1'h0;
    bus(1'h0, ADR_OSC_CONTROL, 32'h0000_0000, {32'h0000_3000, 32'h0000_7000});
    power_save_instruction_exec_i <= 1'h1;
    power_save_instruction_idle_i <= 1'h1;
    @(posedge clk_i);
    power_save_instruction_exec_i <= 1'h0;
    @(posedge clk_i);
    bus(1'h0, ADR_POWER_STATUS, 32'h0000_0000, {32'h0000_0073, 32'h0000_0073});
    wdt_timeout_i <= 1'h1;
    wait_for(wake_o, 8);
    wdt_timeout_i <= 1'h0;
    osc_fail <= 1'h1;
    wait_for(fail_trap_o, 100);
    osc_fail <= 1'h0;
    bus(1'h0, ADR_OSC_CONTROL, 32'h0000_0000, {32'h0000_1008, 32'h0000_7008});
    bus(1'h1, ADR_OSC_CONTROL, 32'h0000_0208, 64'h0);
    bus(1'h1, ADR_OSC_CONTROL, 32'h0000_0280, 64'h0);
    bus(1'h1, ADR_OSC_CONTROL, 32'h0000_0000, 64'h0);
    bus(1'h0, ADR_OSC_CONTROL, 32'h0000_0000, {32'h0000_2280, 32'h0000_7788});
    close_out;
  end

  initial begin
    #(30000 * 100);
    fails++;
    close_out;
  end
endmodule

`default_nettype wire
